// *** verilog/bmfs_pkg.sv ***
// Constants for the battery monitor fault summary register bank.
// Assumes a plain address/strobe register port on a single clock.
package bmfs_pkg;
   localparam int unsigned BMFS_AW          = 6;
   localparam int unsigned BMFS_DW          = 14;
   localparam int unsigned BMFS_N_CELLS     = 12;
   localparam int unsigned BMFS_N_TAPS      = 13;
   localparam int unsigned BMFS_N_TEMPS     = 5;

   localparam logic [5:0] BMFS_ADDR_FAULT   = 6'h04;
   localparam logic [5:0] BMFS_ADDR_SETUP   = 6'h05;
   localparam logic [5:0] BMFS_ADDR_IRQ_ST  = 6'h3e;
   localparam logic [5:0] BMFS_ADDR_IRQ_MSK = 6'h3f;

   // Fault status bit positions
   localparam int unsigned BMFS_B_CLKF  = 2;
   localparam int unsigned BMFS_B_TEMP  = 4;
   localparam int unsigned BMFS_B_HIGH  = 5;
   localparam int unsigned BMFS_B_LOW   = 6;
   localparam int unsigned BMFS_B_BRK   = 7;
   localparam int unsigned BMFS_B_PACK  = 8;
   localparam int unsigned BMFS_B_GND   = 9;
   localparam int unsigned BMFS_B_CSUM  = 10;
   localparam int unsigned BMFS_B_REF   = 11;
   localparam int unsigned BMFS_B_REG   = 12;
   localparam int unsigned BMFS_B_MUX   = 13;

   localparam logic [13:0] BMFS_FAULT_RST   = 14'h0000;
   localparam logic [13:0] BMFS_FAULT_MASK  = 14'h3ff4;
   localparam logic [13:0] BMFS_CLEAR_VALUE = 14'h0000;
   localparam logic [13:0] BMFS_SETUP_RST   = 14'h0000;
   localparam logic [13:0] BMFS_IRQ_MSK_RST = 14'h0000;
endpackage : bmfs_pkg

// *** verilog/bmfs_sync.sv ***
// Three-stage synchroniser with agreement filter for asynchronous inputs.
// Output changes once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module bmfs_sync #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input  wire logic         ref_clk_i,
   input  wire logic         rst_n_i,
   // Data
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] s1_q, s2_q, s3_q, out_q;
   logic [W-1:0] out_d;

   always_comb begin
      out_d = out_q;
      for (int i = 0; i < W; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            out_d[i] = s2_q[i];
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         out_q <= '0;
      end else begin
         s1_q  <= async_i;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         out_q <= out_d;
      end
   end

   assign sync_o = out_q;
endmodule // bmfs_sync
`default_nettype wire

// *** verilog/bmfs_latch_bit.sv ***
// One latched status bit: set beats clear, clear only when allowed.
// Assumes set and clear are synchronous single-cycle or level terms.
`timescale 1ns/1ps
`default_nettype none
module bmfs_latch_bit (
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rst_n_i,
   // Control
   input  wire logic set_i,
   input  wire logic clr_i,
   output logic      bit_o
);
   logic bit_q, bit_d;

   always_comb begin
      bit_d = bit_q;
      if (clr_i) begin
         bit_d = 1'b0;
      end
      // Set wins so a same-cycle event is not lost
      if (set_i) begin
         bit_d = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bit_q <= 1'b0;
      end else begin
         bit_q <= bit_d;
      end
   end

   assign bit_o = bit_q;
endmodule // bmfs_latch_bit
`default_nettype wire

// *** verilog/bmfs_top.sv ***
// Fault status register bank of a battery monitor, with interrupt.
// Assumes per-cell flag registers live outside and feed levels in.
`timescale 1ns/1ps
`default_nettype none
module bmfs_top
   import bmfs_pkg::*;
#(
   parameter int unsigned N_CELLS = BMFS_N_CELLS,
   parameter int unsigned N_TAPS  = BMFS_N_TAPS,
   parameter int unsigned N_TEMPS = BMFS_N_TEMPS
) (
   // Clock and reset
   input  wire logic               ref_clk_i,
   input  wire logic               rst_n_i,
   // Register port
   input  wire logic [5:0]         reg_addr_i,
   input  wire logic [13:0]        reg_wdata_i,
   input  wire logic               reg_wr_i,
   input  wire logic               reg_rd_i,
   output logic      [13:0]        reg_rdata_o,
   // Per-channel flag levels from the flag registers
   input  wire logic [N_CELLS-1:0] per_cell_low_flags_i,
   input  wire logic [N_CELLS-1:0] per_cell_high_flags_i,
   input  wire logic [N_TAPS-1:0]  per_tap_break_flags_i,
   input  wire logic [N_TEMPS-1:0] per_sensor_temp_flags_i,
   // Analog monitor detections, asynchronous levels
   input  wire logic               pack_sense_fail_i,
   input  wire logic               ground_sense_fail_i,
   input  wire logic               fast_osc_fail_i,
   input  wire logic               slow_osc_fail_i,
   input  wire logic               reference_fail_i,
   input  wire logic               regulator_fail_i,
   // Self-test results, synchronous pulses
   input  wire logic               selector_test_fail_i,
   input  wire logic               csum_check_i,
   input  wire logic [13:0]        csum_computed_i,
   input  wire logic [13:0]        csum_stored_i,
   // Outputs
   output logic      [13:0]        cell_setup_control_o,
   output logic                    irq_o
);
   // Synchroniser lanes, one per asynchronous detection
   localparam int unsigned NA     = 6;
   localparam int unsigned L_PACK = 0;
   localparam int unsigned L_GND  = 1;
   localparam int unsigned L_FOSC = 2;
   localparam int unsigned L_SOSC = 3;
   localparam int unsigned L_REF  = 4;
   localparam int unsigned L_REG  = 5;

   // Synchronised detections
   logic [NA-1:0] async_raw;
   logic [NA-1:0] async_s;
   logic          pack_sense_s;
   logic          ground_sense_s;
   logic          fast_osc_s;
   logic          slow_osc_s;
   logic          reference_s;
   logic          regulator_s;

   // Register port decode
   logic          wr_fault;
   logic          wr_setup;
   logic          wr_msk;
   logic          rd_fault;
   logic          rd_setup;
   logic          rd_irq_st;
   logic          rd_irq_msk;
   logic          clr_req;

   // Fault sources and per-bit terms
   logic          any_low;
   logic          any_high;
   logic          any_brk;
   logic          any_temp;
   logic          csum_diff;
   logic          clk_fail;
   logic [13:0]   set_vec;
   logic [13:0]   clr_vec;
   logic [13:0]   fault_s;

   // Registered state and next values
   logic [13:0]   setup_q;
   logic [13:0]   setup_d;
   logic [13:0]   irq_msk_q;
   logic [13:0]   irq_msk_d;
   logic [13:0]   fault_prev_q;
   logic [13:0]   fault_prev_d;
   logic [13:0]   fault_rise;
   logic [13:0]   irq_st_q;
   logic [13:0]   irq_st_d;
   logic          irq_q;
   logic          irq_d;
   logic [13:0]   rdata_q;
   logic [13:0]   rdata_d;

   // Lane order fixes which filtered bit feeds which fault
   assign async_raw[L_PACK] = pack_sense_fail_i;
   assign async_raw[L_GND]  = ground_sense_fail_i;
   assign async_raw[L_FOSC] = fast_osc_fail_i;
   assign async_raw[L_SOSC] = slow_osc_fail_i;
   assign async_raw[L_REF]  = reference_fail_i;
   assign async_raw[L_REG]  = regulator_fail_i;

   // Analog detections come from another domain; filter before use
   bmfs_sync #(
      .W (NA)
   ) u_sync (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .async_i   (async_raw),
      .sync_o    (async_s)
   );

   assign pack_sense_s   = async_s[L_PACK];
   assign ground_sense_s = async_s[L_GND];
   assign fast_osc_s     = async_s[L_FOSC];
   assign slow_osc_s     = async_s[L_SOSC];
   assign reference_s    = async_s[L_REF];
   assign regulator_s    = async_s[L_REG];

   // Write decode; writes to the status address are ignored
   always_comb begin
      wr_fault = 1'b0;
      wr_setup = 1'b0;
      wr_msk   = 1'b0;
      if (reg_wr_i) begin
         case (reg_addr_i)
            BMFS_ADDR_FAULT:   wr_fault = 1'b1;
            BMFS_ADDR_SETUP:   wr_setup = 1'b1;
            BMFS_ADDR_IRQ_MSK: wr_msk   = 1'b1;
            default:           wr_fault = 1'b0;
         endcase
      end
   end

   // Read decode
   always_comb begin
      rd_fault   = 1'b0;
      rd_setup   = 1'b0;
      rd_irq_st  = 1'b0;
      rd_irq_msk = 1'b0;
      if (reg_rd_i) begin
         case (reg_addr_i)
            BMFS_ADDR_FAULT:   rd_fault   = 1'b1;
            BMFS_ADDR_SETUP:   rd_setup   = 1'b1;
            BMFS_ADDR_IRQ_ST:  rd_irq_st  = 1'b1;
            BMFS_ADDR_IRQ_MSK: rd_irq_msk = 1'b1;
            default:           rd_fault   = 1'b0;
         endcase
      end
   end

   // Only an all-zero write to the fault word requests a clear
   assign clr_req = wr_fault && (reg_wdata_i == BMFS_CLEAR_VALUE);

   // Summaries are plain ORs here; latching happens in the bit cells
   assign any_low   = |per_cell_low_flags_i;
   assign any_high  = |per_cell_high_flags_i;
   assign any_brk   = |per_tap_break_flags_i;
   assign any_temp  = |per_sensor_temp_flags_i;
   assign clk_fail  = fast_osc_s | slow_osc_s;
   assign csum_diff = csum_check_i && (csum_computed_i != csum_stored_i);

   // Set terms per bit
   always_comb begin
      set_vec              = 14'h0000;
      set_vec[BMFS_B_CLKF] = clk_fail;
      set_vec[BMFS_B_TEMP] = any_temp;
      set_vec[BMFS_B_HIGH] = any_high;
      set_vec[BMFS_B_LOW]  = any_low;
      set_vec[BMFS_B_BRK]  = any_brk;
      set_vec[BMFS_B_PACK] = pack_sense_s;
      set_vec[BMFS_B_GND]  = ground_sense_s;
      set_vec[BMFS_B_CSUM] = csum_diff;
      set_vec[BMFS_B_REF]  = reference_s;
      set_vec[BMFS_B_REG]  = regulator_s;
      set_vec[BMFS_B_MUX]  = selector_test_fail_i;
   end

   // Summaries keep themselves set while sources stay set, so a zero write
   // cannot clear them until the per-channel registers are cleared first.
   always_comb begin
      clr_vec = BMFS_FAULT_MASK & {14{clr_req}};
   end

   genvar g;
   generate
      for (g = 0; g < 14; g++) begin : g_bits
         if (BMFS_FAULT_MASK[g]) begin : g_live
            bmfs_latch_bit u_bit (
               .ref_clk_i (ref_clk_i),
               .rst_n_i   (rst_n_i),
               .set_i     (set_vec[g]),
               .clr_i     (clr_vec[g]),
               .bit_o     (fault_s[g])
            );
         end else begin : g_rsvd
            assign fault_s[g] = 1'b0;
         end
      end
   endgenerate

   // Cell setup storage, a plain read/write word
   always_comb begin
      setup_d = setup_q;
      if (wr_setup) begin
         setup_d = reg_wdata_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         setup_q <= BMFS_SETUP_RST;
      end else begin
         setup_q <= setup_d;
      end
   end

   // Mask bits outside the fault layout cannot be set
   always_comb begin
      irq_msk_d = irq_msk_q;
      if (wr_msk) begin
         irq_msk_d = reg_wdata_i & BMFS_FAULT_MASK;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_msk_q <= BMFS_IRQ_MSK_RST;
      end else begin
         irq_msk_q <= irq_msk_d;
      end
   end

   // Edge detector resets to the fault reset level, so no false event
   always_comb begin
      fault_prev_d = fault_s;
      fault_rise   = fault_s & ~fault_prev_q;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fault_prev_q <= BMFS_FAULT_RST;
      end else begin
         fault_prev_q <= fault_prev_d;
      end
   end

   // Rising fault bits are events; set wins over the read-clear
   always_comb begin
      irq_st_d = irq_st_q;
      if (rd_irq_st) begin
         irq_st_d = 14'h0000;
      end
      irq_st_d = irq_st_d | fault_rise;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_st_q <= BMFS_FAULT_RST;
      end else begin
         irq_st_q <= irq_st_d;
      end
   end

   // Pin comes from a flop so it cannot glitch toward the host
   always_comb begin
      irq_d = |(irq_st_d & irq_msk_d);
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   // Read data stands one cycle after the strobe and reads zero otherwise
   always_comb begin
      rdata_d = 14'h0000;
      if (rd_fault) begin
         rdata_d = fault_s;
      end
      if (rd_setup) begin
         rdata_d = setup_q;
      end
      if (rd_irq_st) begin
         rdata_d = irq_st_q;
      end
      if (rd_irq_msk) begin
         rdata_d = irq_msk_q;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= 14'h0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata_o          = rdata_q;
   assign cell_setup_control_o = setup_q;
   assign irq_o                = irq_q;
endmodule // bmfs_top
`default_nettype wire

// *** test/bmfs_chk.sv ***
// Port-level checker for the fault summary bank.
// Assumes one clock domain; bound into every bmfs_top instance.
`timescale 1ns/1ps
`default_nettype none
module bmfs_chk
   import bmfs_pkg::*;
#(
   parameter int unsigned N_CELLS = BMFS_N_CELLS,
   parameter int unsigned N_TAPS  = BMFS_N_TAPS,
   parameter int unsigned N_TEMPS = BMFS_N_TEMPS
) (
   // Clock and reset
   input wire logic               ref_clk_i,
   input wire logic               rst_n_i,
   // Register port
   input wire logic [5:0]         reg_addr_i,
   input wire logic [13:0]        reg_wdata_i,
   input wire logic               reg_wr_i,
   input wire logic               reg_rd_i,
   input wire logic [13:0]        reg_rdata_o,
   // Flag sources
   input wire logic [N_CELLS-1:0] per_cell_low_flags_i,
   input wire logic [N_CELLS-1:0] per_cell_high_flags_i,
   input wire logic [N_TAPS-1:0]  per_tap_break_flags_i,
   input wire logic [N_TEMPS-1:0] per_sensor_temp_flags_i,
   input wire logic               csum_check_i,
   input wire logic [13:0]        csum_computed_i,
   input wire logic [13:0]        csum_stored_i
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_rd;
      reg_rd_i && reg_addr_i == BMFS_ADDR_FAULT;
   endsequence
   sequence s_zw;
      reg_wr_i && reg_addr_i == BMFS_ADDR_FAULT && reg_wdata_i == BMFS_CLEAR_VALUE;
   endsequence
   // A source seen high must show in a read issued one cycle later
   property p_sum(src, b);
      src ##1 s_rd |=> reg_rdata_o[b];
   endproperty
   // Set wins over a zero write in the same cycle
   property p_hold(src, b);
      (s_zw ##0 src) ##1 s_rd |=> reg_rdata_o[b];
   endproperty
   property p_clr(src, b);
      (s_zw ##0 !src) ##1 (s_rd ##0 !src) |=> !reg_rdata_o[b];
   endproperty
   chk_low_sets: assert property (p_sum(|per_cell_low_flags_i, BMFS_B_LOW))
      else $error("low summary missing");
   chk_brk_sets: assert property (p_sum(|per_tap_break_flags_i, BMFS_B_BRK))
      else $error("break summary missing");
   chk_high_sets: assert property (p_sum(|per_cell_high_flags_i, BMFS_B_HIGH))
      else $error("high summary missing");
   chk_temp_sets: assert property (p_sum(|per_sensor_temp_flags_i, BMFS_B_TEMP))
      else $error("temp summary missing");
   chk_low_hold: assert property (p_hold(|per_cell_low_flags_i, BMFS_B_LOW))
      else $error("low summary cleared early");
   chk_brk_hold: assert property (p_hold(|per_tap_break_flags_i, BMFS_B_BRK))
      else $error("break summary cleared early");
   chk_low_clear: assert property (p_clr(|per_cell_low_flags_i, BMFS_B_LOW))
      else $error("low summary not cleared");
   chk_temp_clear: assert property (p_clr(|per_sensor_temp_flags_i, BMFS_B_TEMP))
      else $error("temp summary not cleared");
   chk_csum_set: assert property (csum_check_i && csum_computed_i != csum_stored_i ##1 s_rd
      |=> reg_rdata_o[BMFS_B_CSUM]) else $error("checksum flag missing");
endmodule // bmfs_chk
bind bmfs_top bmfs_chk #(.N_CELLS(N_CELLS), .N_TAPS(N_TAPS), .N_TEMPS(N_TEMPS)) i_bmfs_chk (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .per_cell_low_flags_i(per_cell_low_flags_i),
   .per_cell_high_flags_i(per_cell_high_flags_i), .per_tap_break_flags_i(per_tap_break_flags_i),
   .per_sensor_temp_flags_i(per_sensor_temp_flags_i), .csum_check_i(csum_check_i),
   .csum_computed_i(csum_computed_i), .csum_stored_i(csum_stored_i));
`default_nettype wire

// *** test/bmfs_top_tb.sv ***
// Self-checking bench for the fault summary bank.
// Assumes reads answer one cycle later and the bank never stalls.
`timescale 1ns/1ps
`default_nettype none
module bmfs_top_tb
   import bmfs_pkg::*;
;
   logic        clk, rst_n, wr, rd, sel, cchk, irq;
   logic [5:0]  addr, af;
   logic [13:0] wdata, rdata, cmp, sto, setup;
   logic [11:0] lo, hi;
   logic [12:0] tap;
   logic [4:0]  tmp;
   int          miscompares, n_checks;
   int          sb[4] = '{BMFS_B_LOW, BMFS_B_BRK, BMFS_B_HIGH, BMFS_B_TEMP};
   int          ab[6] = '{BMFS_B_PACK, BMFS_B_GND, BMFS_B_CLKF, BMFS_B_CLKF, BMFS_B_REF, BMFS_B_REG};
   bmfs_top i_bmfs_top (.ref_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .per_cell_low_flags_i(lo),
      .per_cell_high_flags_i(hi), .per_tap_break_flags_i(tap), .per_sensor_temp_flags_i(tmp),
      .pack_sense_fail_i(af[0]), .ground_sense_fail_i(af[1]), .fast_osc_fail_i(af[2]),
      .slow_osc_fail_i(af[3]), .reference_fail_i(af[4]), .regulator_fail_i(af[5]),
      .selector_test_fail_i(sel), .csum_check_i(cchk), .csum_computed_i(cmp),
      .csum_stored_i(sto), .cell_setup_control_o(setup), .irq_o(irq));
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [13:0] seen, input logic [13:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Each call drives every strobe, so a strobe never lingers
   task automatic op(input logic w, input logic r, input logic [5:0] a, input logic [13:0] d);
      @(posedge clk);
      wr <= w;
      rd <= r;
      addr <= a;
      wdata <= d;
   endtask
   task automatic idle(input int n);
      repeat (n) op(1'b0, 1'b0, 6'h00, 14'h0000);
   endtask
   task automatic wreg(input logic [5:0] a, input logic [13:0] d);
      op(1'b1, 1'b0, a, d);
   endtask
   task automatic rreg(input logic [5:0] a, input logic [13:0] exp, input string nm);
      op(1'b0, 1'b1, a, 14'h0000);
      idle(1);
      @(negedge clk);
      chk(nm, rdata, exp);
   endtask
   task automatic src(input int k, input logic v);
      idle(1);
      case (k)
         0: lo[11] <= v;
         1: tap[12] <= v;
         2: hi[11] <= v;
         default: tmp[4] <= v;
      endcase
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      final_report();
   end
   initial begin
      logic [13:0] m;
      {rst_n, wr, rd, sel, cchk, addr, af, wdata, cmp, sto, lo, hi, tap, tmp} = '0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rreg(BMFS_ADDR_FAULT, BMFS_FAULT_RST, "fault rst");
      rreg(BMFS_ADDR_SETUP, BMFS_SETUP_RST, "setup rst");
      rreg(BMFS_ADDR_IRQ_ST, 14'h0000, "irq st rst");
      $display("done reset");
      wreg(BMFS_ADDR_IRQ_MSK, 14'h0000);
      src(0, 1'b1);
      src(0, 1'b0);
      idle(2);
      @(negedge clk);
      chk("irq masked", {13'h0, irq}, 14'h0000);
      wreg(BMFS_ADDR_IRQ_MSK, 14'h0040);
      idle(1);
      @(negedge clk);
      chk("irq on", {13'h0, irq}, 14'h0001);
      rreg(BMFS_ADDR_IRQ_ST, 14'h0040, "irq st");
      chk("irq off", {13'h0, irq}, 14'h0000);
      $display("done irq");
      for (int k = 0; k < 4; k++) begin
         m = 14'h0001 << sb[k];
         wreg(BMFS_ADDR_FAULT, BMFS_CLEAR_VALUE);
         src(k, 1'b1);
         wreg(BMFS_ADDR_FAULT, BMFS_CLEAR_VALUE);
         rreg(BMFS_ADDR_FAULT, m, "sum held");
         src(k, 1'b0);
         wreg(BMFS_ADDR_FAULT, 14'h3fff);
         rreg(BMFS_ADDR_FAULT, m, "sum latched");
         wreg(BMFS_ADDR_FAULT, BMFS_CLEAR_VALUE);
         rreg(BMFS_ADDR_FAULT, 14'h0000, "sum clear");
      end
      $display("done summaries");
      for (int i = 0; i < 6; i++) begin
         m = 14'h0001 << ab[i];
         idle(1);
         af <= 6'h01 << i;
         idle(6);
         wreg(BMFS_ADDR_FAULT, BMFS_CLEAR_VALUE);
         rreg(BMFS_ADDR_FAULT, m, "async set");
         idle(1);
         af <= 6'h00;
         idle(6);
         wreg(BMFS_ADDR_FAULT, BMFS_CLEAR_VALUE);
         rreg(BMFS_ADDR_FAULT, 14'h0000, "async clear");
      end
      $display("done sense");
      idle(1);
      {cchk, sel, cmp, sto} <= {2'b11, 14'h1234, 14'h1234};
      idle(1);
      {cchk, sel} <= 2'b00;
      rreg(BMFS_ADDR_FAULT, 14'h2000, "csum match");
      wreg(BMFS_ADDR_FAULT, BMFS_CLEAR_VALUE);
      idle(1);
      {cchk, sto} <= {1'b1, 14'h1235};
      op(1'b0, 1'b1, BMFS_ADDR_FAULT, 14'h0000);
      cchk <= 1'b0;
      idle(1);
      @(negedge clk);
      chk("csum diff", rdata, 14'h0400);
      $display("done csum");
      wreg(BMFS_ADDR_SETUP, 14'h2a5c);
      wreg(6'h10, 14'h3fff);
      rreg(6'h10, 14'h0000, "unmapped");
      rreg(BMFS_ADDR_SETUP, 14'h2a5c, "setup");
      chk("setup out", setup, 14'h2a5c);
      $display("done regs");
      final_report();
   end
endmodule // bmfs_top_tb
`default_nettype wire
